//--- logic/pmc_top.sv
`timescale 1ns/1ps
module pmc_top #(
   parameter int IRQS        = pmc_pkg::IRQ_COUNT,
   parameter int WAKE_CYCLES = pmc_pkg::DEEP_WAKE_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   supply_ok,
   input  wire logic                   brownout,
   input  wire logic                   wdt_reset,
   input  wire logic                   sw_reset,
   input  wire pmc_pkg::pmc_lp_req_type lp_req,
   input  wire logic [IRQS-1:0]        irq,
   input  wire logic [IRQS-1:0]        irq_enable,
   input  wire logic                   i2c_addr_match,
   input  wire logic                   rc_clear,
   output pmc_pkg::pmc_clk_type        clk_gate,
   output pmc_pkg::pmc_mode_type       mode,
   output logic                        dev_reset_n,
   output logic                        wake_pending,
   output logic                        lfo_clk,
   output logic [3:0]                  reset_cause
);
   // ==========================================================
   // input synchronisers
   logic [IRQS-1:0] irq_s;
   logic            sup_s;
   logic            bod_s;
   logic            i2c_s;

   pmc_sync #(.WIDTH(IRQS + 3)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({irq, supply_ok, brownout, i2c_addr_match}),
      .q     ({irq_s, sup_s, bod_s, i2c_s})
   );

   // ==========================================================
   // wake sources
   logic wake_irq;
   logic wake_any;
   logic lp_ok;

   assign wake_irq = |(irq_s & irq_enable);
   assign wake_any = wake_irq | i2c_s;
   assign lp_ok    = lp_req.req & ~wake_any;

   // ==========================================================
   // mode state
   typedef enum logic [2:0] {
      ST_POWERUP,
      ST_ACTIVE,
      ST_SLEEP,
      ST_DEEP,
      ST_WAKING
   } pmc_state_type;

   pmc_state_type state_q;
   pmc_state_type state_d;
   logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_q;
   logic wake_done;

   assign wake_done = (wake_cnt_q == ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES - 1));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_POWERUP: begin
            if (sup_s) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (lp_ok) begin
               state_d = lp_req.deep ? ST_DEEP : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_any) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_DEEP: begin
            if (wake_any) begin
               state_d = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (wake_done) begin
               state_d = ST_ACTIVE;
            end
         end
         default: state_d = ST_POWERUP;
      endcase
      // override lives here so the registered gates and mode follow it too
      if (bod_s || !sup_s) begin
         state_d = ST_POWERUP;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_POWERUP;
      end else begin
         state_q <= state_d;
      end
   end

   // fixed latency: counter runs the full WAKE_CYCLES (35 us by default) unless brownout or supply loss forces powerup
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_q <= '0;
      end else if (state_q != ST_WAKING) begin
         wake_cnt_q <= '0;
      end else if (!wake_done) begin
         wake_cnt_q <= wake_cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // clock gates and mode output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_gate <= '0;
         mode     <= pmc_pkg::PMC_MODE_ACTIVE;
      end else begin
         clk_gate.lfo_en <= 1'b1;
         unique case (state_d)
            ST_ACTIVE: begin
               clk_gate.cpu_clk_en    <= 1'b1;
               clk_gate.flash_clk_en  <= 1'b1;
               clk_gate.sram_clk_en   <= 1'b1;
               clk_gate.periph_clk_en <= 1'b1;
               clk_gate.hf_clk_en     <= 1'b1;
               mode                   <= pmc_pkg::PMC_MODE_ACTIVE;
            end
            ST_SLEEP: begin
               clk_gate.cpu_clk_en    <= 1'b0;
               clk_gate.flash_clk_en  <= 1'b0;
               clk_gate.sram_clk_en   <= 1'b0;
               clk_gate.periph_clk_en <= 1'b1;
               clk_gate.hf_clk_en     <= 1'b1;
               mode                   <= pmc_pkg::PMC_MODE_SLEEP;
            end
            ST_DEEP, ST_WAKING: begin
               clk_gate.cpu_clk_en    <= 1'b0;
               clk_gate.flash_clk_en  <= 1'b0;
               clk_gate.sram_clk_en   <= 1'b0;
               clk_gate.periph_clk_en <= 1'b0;
               clk_gate.hf_clk_en     <= (state_d == ST_WAKING);
               mode                   <= pmc_pkg::PMC_MODE_DEEP;
            end
            default: begin
               clk_gate.cpu_clk_en    <= 1'b0;
               clk_gate.flash_clk_en  <= 1'b0;
               clk_gate.sram_clk_en   <= 1'b0;
               clk_gate.periph_clk_en <= 1'b0;
               clk_gate.hf_clk_en     <= 1'b0;
               mode                   <= pmc_pkg::PMC_MODE_ACTIVE;
            end
         endcase
      end
   end

   // ==========================================================
   // device reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_reset_n <= 1'b0;
      end else begin
         dev_reset_n <= ~(bod_s | ~sup_s | wdt_reset | sw_reset) & (state_q != ST_POWERUP);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_pending <= 1'b0;
      end else begin
         wake_pending <= wake_any & (state_q == ST_DEEP || state_q == ST_SLEEP);
      end
   end

   // ==========================================================
   // low-frequency oscillator model, divided from clk
   logic [$clog2(pmc_pkg::LFO_HALF_CYCLES)-1:0] lfo_cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfo_cnt_q <= '0;
         lfo_clk   <= 1'b0;
      end else if (lfo_cnt_q == ($clog2(pmc_pkg::LFO_HALF_CYCLES))'(pmc_pkg::LFO_HALF_CYCLES - 1)) begin
         lfo_cnt_q <= '0;
         lfo_clk   <= ~lfo_clk;
      end else begin
         lfo_cnt_q <= lfo_cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // reset cause: sticky, not cleared by rst_n, so it lives past device reset;
   // limitation: no async reset, so it powers up unknown until the first clock edge
   logic [3:0] rc_q;
   logic       por_seen_q;

   always_ff @(posedge clk) begin
      if (por_seen_q) begin
         if (rc_clear) begin
            rc_q <= pmc_pkg::RC_RESET;
         end
         // set beats clear
         if (!sup_s) begin
            rc_q[pmc_pkg::RC_POR_BIT] <= 1'b1;
         end
         if (bod_s) begin
            rc_q[pmc_pkg::RC_BOD_BIT] <= 1'b1;
         end
         if (wdt_reset) begin
            rc_q[pmc_pkg::RC_WDT_BIT] <= 1'b1;
         end
         if (sw_reset) begin
            rc_q[pmc_pkg::RC_SW_BIT] <= 1'b1;
         end
      end else begin
         // flag not yet known at power-up: record starts empty
         rc_q <= pmc_pkg::RC_RESET;
      end
   end

   always_ff @(posedge clk) begin
      por_seen_q <= por_seen_q | rst_n;
   end

   assign reset_cause = rc_q;

   // ==========================================================
   // checks
   // helper: length of the waking run, kept apart from the design counter
   localparam int WL = $clog2(WAKE_CYCLES + 2);
   logic [WL-1:0] wake_len_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_len_q <= '0;
      end else if (state_q == ST_WAKING) begin
         wake_len_q <= wake_len_q + 1'b1;
      end else begin
         wake_len_q <= '0;
      end
   end

   a_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == pmc_pkg::PMC_MODE_SLEEP) |-> (!clk_gate.cpu_clk_en && clk_gate.periph_clk_en))
      else $error("sleep gates wrong");

   a_active_clk: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == pmc_pkg::PMC_MODE_ACTIVE && state_q == ST_ACTIVE) |-> (clk_gate.cpu_clk_en && clk_gate.hf_clk_en))
      else $error("active clocks off");

   a_deep_hf_off: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_DEEP) |-> !clk_gate.hf_clk_en)
      else $error("hf clock on in deep");

   a_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_SLEEP && wake_any && sup_s && !bod_s) |=> (state_q == ST_ACTIVE))
      else $error("sleep wake slow");

   sequence s_deep_wake;
      state_q == ST_DEEP && wake_any && sup_s && !bod_s;
   endsequence
   sequence s_wake_hold;
      (state_q == ST_WAKING)[*8];
   endsequence
   a_deep_latency: assert property (@(posedge clk) disable iff (!rst_n || bod_s || !sup_s)
      s_deep_wake |=> s_wake_hold)
      else $error("deep wake cut short");

   a_wake_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(state_q) == ST_WAKING && state_q == ST_ACTIVE) |-> (wake_len_q == WL'(WAKE_CYCLES)))
      else $error("deep wake latency");

   a_powerup_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !sup_s |=> (state_q == ST_POWERUP))
      else $error("mode entered without supply");

   a_bod_reset: assert property (@(posedge clk) disable iff (!rst_n)
      bod_s |=> !dev_reset_n)
      else $error("brownout no reset");

   a_deep_exit: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_DEEP && $past(state_q) == ST_DEEP && !wake_any && sup_s && !bod_s) |=> (state_q == ST_DEEP))
      else $error("deep exit without wake");

   a_lp_entry: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_ACTIVE && lp_ok && lp_req.deep && sup_s && !bod_s) |=> (state_q == ST_DEEP))
      else $error("deep request ignored");

   a_cause_bod: assert property (@(posedge clk) disable iff (!rst_n)
      bod_s |=> reset_cause[pmc_pkg::RC_BOD_BIT])
      else $error("brownout cause lost");
endmodule

//--- logic/pmc_pkg.sv
package pmc_pkg;

   // ==========================================================
   // modes
   typedef enum logic [1:0] {
      PMC_MODE_ACTIVE,
      PMC_MODE_SLEEP,
      PMC_MODE_DEEP
   } pmc_mode_type;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int DEEP_WAKE_US       = 35;
   localparam int DEEP_WAKE_CYCLES   = (DEEP_WAKE_US * 1000) / CLK_PERIOD_NS;
   localparam int LFO_HZ             = 40000;
   localparam int LFO_HALF_CYCLES    = (1000000000 / CLK_PERIOD_NS) / (LFO_HZ * 2);
   localparam int IRQ_COUNT          = 8;

   // ==========================================================
   // reset cause bit positions
   localparam int RC_POR_BIT         = 0;
   localparam int RC_BOD_BIT         = 1;
   localparam int RC_WDT_BIT         = 2;
   localparam int RC_SW_BIT          = 3;
   localparam logic [3:0] RC_RESET   = 4'h0;

   // ==========================================================
   // clock gate bundle
   typedef struct packed {
      logic cpu_clk_en;
      logic flash_clk_en;
      logic sram_clk_en;
      logic periph_clk_en;
      logic hf_clk_en;
      logic lfo_en;
   } pmc_clk_type;

   // low-power request from the processor
   typedef struct packed {
      logic req;
      logic deep;
   } pmc_lp_req_type;

endpackage

//--- logic/pmc_sync.sv
`timescale 1ns/1ps
module pmc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   // ==========================================================
   // three stages; change counts once stage two and three agree
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

//--- sim/pmc_core_model.sv
`timescale 1ns/1ps
module pmc_core_model (
   input  wire logic                  clk,
   input  wire pmc_pkg::pmc_mode_type mode,
   input  wire logic                  go,
   input  wire logic                  deep,
   output pmc_pkg::pmc_lp_req_type    lp_req
);
   // ==========================================
   // processor side: request held until mode leaves active
   initial lp_req = '0;
   always @(negedge clk) begin
      if (go) begin
         lp_req <= '{req: 1'b1, deep: deep};
      end else if (lp_req.req && mode != pmc_pkg::PMC_MODE_ACTIVE) begin
         lp_req <= '0;
      end
   end
endmodule

//--- sim/pmc_top_tb_top.sv
`timescale 1ns/1ps
module pmc_top_tb_top;
   localparam int WAKE = 16;
   logic clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b0, brownout = 1'b0;
   logic wdt_reset = 1'b0, sw_reset = 1'b0, i2c_addr_match = 1'b0, rc_clear = 1'b0;
   logic go = 1'b0, deep = 1'b0, saw_rst, saw_wp;
   logic [7:0] irq = 8'h00, irq_enable = 8'h00;
   pmc_pkg::pmc_lp_req_type lp_req;
   pmc_pkg::pmc_clk_type    clk_gate;
   pmc_pkg::pmc_mode_type   mode;
   logic       dev_reset_n, wake_pending, lfo_clk, lfo_was;
   logic [3:0] reset_cause;
   int         mismatches = 0, checked = 0, n, j, exp_mode;

   always #5 clk = ~clk;

   pmc_top #(.WAKE_CYCLES(WAKE)) pmc_top_i (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
      .brownout(brownout), .wdt_reset(wdt_reset), .sw_reset(sw_reset), .lp_req(lp_req), .irq(irq),
      .irq_enable(irq_enable), .i2c_addr_match(i2c_addr_match), .rc_clear(rc_clear),
      .clk_gate(clk_gate), .mode(mode), .dev_reset_n(dev_reset_n), .wake_pending(wake_pending),
      .lfo_clk(lfo_clk), .reset_cause(reset_cause));
   pmc_core_model pmc_core_model_i (.clk(clk), .mode(mode), .go(go), .deep(deep), .lp_req(lp_req));

   // ==========================================
   // model and checks
   function automatic logic [3:0] gates_for(int m);
      // {cpu, flash, sram, hf}
      return (m == 0) ? 4'hf : (m == 1) ? 4'h1 : 4'h0;
   endfunction

   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_state();
      chk("mode", 8'(mode), 8'(exp_mode));
      chk("gates", {4'h0, clk_gate.cpu_clk_en, clk_gate.flash_clk_en, clk_gate.sram_clk_en,
          clk_gate.hf_clk_en}, {4'h0, gates_for(exp_mode)});
   endtask

   // bounded waits, all sampled at the falling edge
   task automatic wait_mode(pmc_pkg::pmc_mode_type m, int lim);
      n = 0;
      saw_wp = 1'b0;
      while (mode !== m && n < lim) begin
         @(negedge clk);
         n++;
         if (wake_pending === 1'b1) saw_wp = 1'b1;
         if (n == 4) i2c_addr_match = 1'b0;
      end
   endtask

   task automatic wait_cpu_on();
      n = 0;
      while (clk_gate.cpu_clk_en !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("cpu clock back", 8'(n < 40), 8'h01);
   endtask

   task automatic enter(logic d, pmc_pkg::pmc_mode_type m);
      // non-blocking so the model's falling-edge read sees a settled value
      deep = d;
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      wait_mode(m, 10);
      repeat (2) @(negedge clk);
   endtask

   task automatic end_of_test();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // scenarios
   initial begin
      void'($urandom(32'hba8f));
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk("cpu gated before supply good", 8'(clk_gate.cpu_clk_en), 8'h00);
      supply_ok = 1'b1;
      wait_cpu_on();
      exp_mode = 0;
      check_state();
      // sleep and wake on each irq line, random extra enables
      for (int i = 0; i < 8; i++) begin
         irq_enable = 8'(1 << i) | 8'($urandom);
         enter(1'b0, pmc_pkg::PMC_MODE_SLEEP);
         exp_mode = 1;
         check_state();
         chk("periph in sleep", 8'(clk_gate.periph_clk_en), 8'h01);
         irq = 8'(1 << i);
         wait_mode(pmc_pkg::PMC_MODE_ACTIVE, 8);
         chk("sleep wake fast", 8'(n < 8), 8'h01);
         chk("wake pending sleep", 8'(saw_wp), 8'h01);
         irq = 8'h00;
         repeat (6) @(negedge clk);
         exp_mode = 0;
         check_state();
      end
      // deep sleep: disabled irqs refused, then i2c match and enabled irq
      for (int k = 0; k < 2; k++) begin
         irq_enable = 8'h00;
         enter(1'b1, pmc_pkg::PMC_MODE_DEEP);
         exp_mode = 2;
         check_state();
         chk("lfo on in deep", 8'(clk_gate.lfo_en), 8'h01);
         irq = 8'hff;
         lfo_was = lfo_clk;
         n = 0;
         while (lfo_clk === lfo_was && n < 2 * pmc_pkg::LFO_HALF_CYCLES + 4) begin
            @(negedge clk);
            n++;
         end
         chk("lfo toggles in deep", 8'(n < 2 * pmc_pkg::LFO_HALF_CYCLES + 4), 8'h01);
         chk("disabled irq no wake", 8'(mode), 8'(exp_mode));
         irq = 8'h00;
         repeat (6) @(negedge clk);
         if (k == 0) begin
            i2c_addr_match = 1'b1;
         end else begin
            j = $urandom % 8;
            irq_enable = 8'(1 << j);
            irq = 8'(1 << j);
         end
         wait_mode(pmc_pkg::PMC_MODE_ACTIVE, 100);
         chk("deep wake latency", 8'(n >= WAKE && n <= WAKE + 8), 8'h01);
         chk("wake pending deep", 8'(saw_wp), 8'h01);
         irq = 8'h00;
         repeat (6) @(negedge clk);
         exp_mode = 0;
         check_state();
      end
      // reset sources and sticky cause record
      for (int c = 1; c < 4; c++) begin
         rc_clear = 1'b1;
         @(negedge clk);
         rc_clear = 1'b0;
         brownout = (c == pmc_pkg::RC_BOD_BIT);
         wdt_reset = (c == pmc_pkg::RC_WDT_BIT);
         sw_reset = (c == pmc_pkg::RC_SW_BIT);
         saw_rst = 1'b0;
         repeat (8) begin
            @(negedge clk);
            if (dev_reset_n === 1'b0) saw_rst = 1'b1;
            // brownout is a pin level: held long enough to pass the filter
            {wdt_reset, sw_reset} = 2'h0;
         end
         brownout = 1'b0;
         chk("device reset", 8'(saw_rst), 8'h01);
         chk("cause", 8'(reset_cause), 8'(1 << c));
         wait_cpu_on();
      end
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("cause sticky", 8'(reset_cause[pmc_pkg::RC_SW_BIT]), 8'h01);
      wait_cpu_on();
      end_of_test();
   end

   // ==========================================
   // watchdog, a few times the expected run
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
endmodule
